/* File: common/wdt_pkg.sv */
// Constants, register map and carrier types of the window watchdog timer.
// Assumes a single aclk domain at 20 MHz and an AXI4-Lite master with 32-bit data.
// Function
// - Watchdog runs after every reset without any software arming.
// - Disable and enable commands stop and resume the watchdog at any time.
// - Counter overflow without service raises a reset request.
// - Service inside the forbidden window while running raises a reset request instead of reloading; while stopped it reloads.
// - 16-bit counter, system or wake-up clock, divided by 16384 or 256.
// - Each valid service loads the counter from the reload value register.
// - Reset defaults give about 0.13 s from the 500 kHz wake-up clock.
package wdt_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CONTROL    = 8'h00;
    localparam logic [7:0] OFF_RELOAD     = 8'h04;
    localparam logic [7:0] OFF_WINDOW     = 8'h08;
    localparam logic [7:0] OFF_COMMAND    = 8'h0c;
    localparam logic [7:0] OFF_STATE      = 8'h10;
    localparam logic [7:0] OFF_INT_STATUS = 8'h14;
    localparam logic [7:0] OFF_INT_CLEAR  = 8'h18;
    localparam logic [7:0] OFF_INT_ENABLE = 8'h1c;

    // ----------------------------------------------------------------
    // Field positions and widths
    // ----------------------------------------------------------------
    localparam int COUNT_W        = 16;
    localparam int PRESCALE_W     = 14;
    localparam int INT_W          = 2;
    localparam int STATE_RUN_BIT  = 16;
    localparam int DIV_LOW        = 256;
    localparam int DIV_HIGH       = 16384;

    // ----------------------------------------------------------------
    // Timing and reset values
    // ----------------------------------------------------------------
    localparam int CLK_FREQ_HZ         = 20_000_000;
    localparam int WU_FREQ_HZ          = 500_000;
    localparam int DEFAULT_INTERVAL_US = 130_000;
    localparam int DEFAULT_TICKS       = DEFAULT_INTERVAL_US * (WU_FREQ_HZ / 1000) / 1000 / DIV_LOW;
    localparam logic [15:0] RELOAD_RESET  = 16'(65536 - DEFAULT_TICKS);
    localparam logic [15:0] WINDOW_RESET  = 16'h0000;
    localparam logic [15:0] COUNT_MAX     = 16'hffff;
    localparam logic        CLK_SEL_RESET = 1'b1;
    localparam logic        DIV_SEL_RESET = 1'b0;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // ----------------------------------------------------------------
    // Carrier types
    // ----------------------------------------------------------------
    // clk_sel: 1 wake-up clock, 0 system clock; div_sel: 1 divide 16384, 0 divide 256
    typedef struct packed {
        logic div_sel;
        logic clk_sel;
    } control_t;

    typedef struct packed {
        logic enable;
        logic halt;
        logic service;
    } command_t;

    typedef struct packed {
        logic window_violation;
        logic overflow;
    } events_t;

endpackage

/* File: logic/wdt_prescaler.sv */
// Count clock divider of the window watchdog.
// Assumes the wake-up clock input is already synchronous to aclk.
`timescale 1ns/10ps
module wdt_prescaler #(
    parameter int DIV_LOW  = 256,
    parameter int DIV_HIGH = 16384
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             run,
    input  wire logic             clear,
    input  wire wdt_pkg::control_t ctrl,
    input  wire logic             wakeup_level,
    output logic                  tick
);
    localparam int W = $clog2(DIV_HIGH);

    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;
    logic         wu_prev_reg;
    logic         tick_reg;
    logic         tick_next;
    logic [W-1:0] limit;
    logic         src_pulse;

    // ----------------------------------------------------------------
    // Divider
    // ----------------------------------------------------------------
    always_comb begin
        limit      = ctrl.div_sel ? W'(DIV_HIGH - 1) : W'(DIV_LOW - 1);
        // Wake-up source counts its rising edges, system source every aclk
        src_pulse  = ctrl.clk_sel ? (wakeup_level & ~wu_prev_reg) : 1'b1;
        count_next = count_reg;
        tick_next  = 1'b0;
        if (clear || !run) begin
            count_next = '0;
        end else if (src_pulse) begin
            if (count_reg >= limit) begin
                count_next = '0;
                tick_next  = 1'b1;
            end else begin
                count_next = count_reg + W'(1);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_reg   <= '0;
            wu_prev_reg <= 1'b0;
            tick_reg    <= 1'b0;
        end else begin
            count_reg   <= count_next;
            wu_prev_reg <= wakeup_level;
            tick_reg    <= tick_next;
        end
    end

    assign tick = tick_reg;

endmodule // wdt_prescaler

/* File: logic/window_watchdog_timer.sv */
// Window watchdog timer with an AXI4-Lite register slave and interrupt logic.
// Assumes one aclk domain, synchronous active-low reset, and an external reset
// controller that acts on the reset_request pulse.
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module window_watchdog_timer #(
    parameter int ADDR_W = 8
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic              wakeup_oscillator_clock,
    output logic                   reset_request,
    output logic                   irq
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic              aw_held_reg,  aw_held_next;
    logic [7:0]        aw_addr_reg,  aw_addr_next;
    logic              w_held_reg,   w_held_next;
    logic [31:0]       w_data_reg,   w_data_next;
    logic [3:0]        w_strb_reg,   w_strb_next;
    logic              awready_reg,  awready_next;
    logic              wready_reg,   wready_next;
    logic              bvalid_reg,   bvalid_next;
    logic [1:0]        bresp_reg,    bresp_next;
    logic              arready_reg,  arready_next;
    logic              rvalid_reg,   rvalid_next;
    logic [31:0]       rdata_reg,    rdata_next;
    logic [1:0]        rresp_reg,    rresp_next;
    wdt_pkg::control_t ctrl_reg,     ctrl_next;
    logic [15:0]       reload_reg,   reload_next;
    logic [15:0]       window_reg,   window_next;
    logic [15:0]       count_reg,    count_next;
    logic              running_reg,  running_next;
    logic              rst_req_reg,  rst_req_next;
    wdt_pkg::events_t  int_stat_reg, int_stat_next;
    wdt_pkg::events_t  int_en_reg,   int_en_next;
    logic              irq_reg,      irq_next;

    logic              do_write;
    logic              addr_ok;
    logic [31:0]       wr_val;
    wdt_pkg::command_t cmd;
    wdt_pkg::events_t  ev;
    wdt_pkg::events_t  clr_mask;
    logic              svc_req;
    logic              svc_ok;
    logic              svc_bad;
    logic              overflow;
    logic              tick;

    // Byte lanes that are not strobed keep their old contents
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = data[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a[1:0] == 2'h0 && a <= wdt_pkg::OFF_INT_ENABLE;
    endfunction

    // ----------------------------------------------------------------
    // Count clock divider
    // ----------------------------------------------------------------
    wdt_prescaler #(
        .DIV_LOW  (wdt_pkg::DIV_LOW),
        .DIV_HIGH (wdt_pkg::DIV_HIGH)
    ) u_prescaler (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .run          (running_reg),
        .clear        (svc_ok),
        .ctrl         (ctrl_reg),
        .wakeup_level (wakeup_oscillator_clock),
        .tick         (tick)
    );

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        // Bus write side: address and data are taken in either order
        aw_held_next = aw_held_reg;
        aw_addr_next = aw_addr_reg;
        w_held_next  = w_held_reg;
        w_data_next  = w_data_reg;
        w_strb_next  = w_strb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        if (awvalid && awready_reg) begin
            aw_held_next = 1'b1;
            aw_addr_next = 8'(awaddr);
        end
        if (wvalid && wready_reg) begin
            w_held_next = 1'b1;
            w_data_next = wdata;
            w_strb_next = wstrb;
        end
        if (bvalid_reg && bready) begin
            bvalid_next = 1'b0;
        end
        do_write = aw_held_reg && w_held_reg && !bvalid_reg;
        addr_ok  = mapped(aw_addr_reg);
        wr_val   = 32'h0;
        if (do_write) begin
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = addr_ok ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_SLVERR;
        end
        awready_next = !aw_held_next && !bvalid_next;
        wready_next  = !w_held_next && !bvalid_next;

        // Register writes
        ctrl_next   = ctrl_reg;
        reload_next = reload_reg;
        window_next = window_reg;
        int_en_next = int_en_reg;
        cmd         = '0;
        clr_mask    = '0;
        if (do_write) begin
            unique case (aw_addr_reg)
                wdt_pkg::OFF_CONTROL: begin
                    wr_val    = merge({30'h0, ctrl_reg}, w_data_reg, w_strb_reg);
                    ctrl_next = wdt_pkg::control_t'(wr_val[1:0]);
                end
                wdt_pkg::OFF_RELOAD: begin
                    wr_val      = merge({16'h0, reload_reg}, w_data_reg, w_strb_reg);
                    reload_next = wr_val[15:0];
                end
                wdt_pkg::OFF_WINDOW: begin
                    wr_val      = merge({16'h0, window_reg}, w_data_reg, w_strb_reg);
                    window_next = wr_val[15:0];
                end
                wdt_pkg::OFF_COMMAND: begin
                    wr_val = merge(32'h0, w_data_reg, w_strb_reg);
                    cmd    = wdt_pkg::command_t'(wr_val[2:0]);
                end
                wdt_pkg::OFF_INT_CLEAR: begin
                    wr_val   = merge(32'h0, w_data_reg, w_strb_reg);
                    clr_mask = wdt_pkg::events_t'(wr_val[1:0]);
                end
                wdt_pkg::OFF_INT_ENABLE: begin
                    wr_val      = merge({30'h0, int_en_reg}, w_data_reg, w_strb_reg);
                    int_en_next = wdt_pkg::events_t'(wr_val[1:0]);
                end
                default: begin
                    wr_val = 32'h0;
                end
            endcase
        end

        // Watchdog core
        svc_req  = cmd.service;
        // A stopped watchdog has no window to violate; the service just reloads
        svc_bad  = svc_req && running_reg && (count_reg < window_reg);
        svc_ok   = svc_req && !svc_bad;
        overflow = running_reg && tick && (count_reg == wdt_pkg::COUNT_MAX) && !svc_req;
        count_next = count_reg;
        if (svc_ok) begin
            count_next = reload_reg;
        end else if (overflow) begin
            count_next = reload_reg;
        end else if (running_reg && tick) begin
            count_next = count_reg + 16'h0001;
        end
        // Disable wins when both commands come in one write
        running_next = running_reg;
        if (cmd.halt) begin
            running_next = 1'b0;
        end else if (cmd.enable) begin
            running_next = 1'b1;
        end
        rst_req_next = overflow || svc_bad;

        // Interrupt status: a new event beats a clear in the same cycle
        ev.overflow         = overflow;
        ev.window_violation = svc_bad;
        int_stat_next       = (int_stat_reg & ~clr_mask) | ev;
        irq_next            = |(int_stat_next & int_en_next);

        // Bus read side
        arready_next = arready_reg;
        rvalid_next  = rvalid_reg;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        if (rvalid_reg && rready) begin
            rvalid_next = 1'b0;
        end
        if (arvalid && arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next  = mapped(8'(araddr)) ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_SLVERR;
            unique case (8'(araddr))
                wdt_pkg::OFF_CONTROL:    rdata_next = {30'h0, ctrl_reg};
                wdt_pkg::OFF_RELOAD:     rdata_next = {16'h0, reload_reg};
                wdt_pkg::OFF_WINDOW:     rdata_next = {16'h0, window_reg};
                wdt_pkg::OFF_STATE:      rdata_next = {15'h0, running_reg, count_reg};
                wdt_pkg::OFF_INT_STATUS: rdata_next = {30'h0, int_stat_reg};
                wdt_pkg::OFF_INT_ENABLE: rdata_next = {30'h0, int_en_reg};
                default:                 rdata_next = 32'h0;
            endcase
        end
        arready_next = !rvalid_next;
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg  <= 1'b0;
            aw_addr_reg  <= 8'h00;
            w_held_reg   <= 1'b0;
            w_data_reg   <= 32'h0;
            w_strb_reg   <= 4'h0;
            awready_reg  <= 1'b0;
            wready_reg   <= 1'b0;
            bvalid_reg   <= 1'b0;
            bresp_reg    <= wdt_pkg::RESP_OKAY;
            arready_reg  <= 1'b0;
            rvalid_reg   <= 1'b0;
            rdata_reg    <= 32'h0;
            rresp_reg    <= wdt_pkg::RESP_OKAY;
            ctrl_reg     <= '{div_sel: wdt_pkg::DIV_SEL_RESET, clk_sel: wdt_pkg::CLK_SEL_RESET};
            reload_reg   <= wdt_pkg::RELOAD_RESET;
            window_reg   <= wdt_pkg::WINDOW_RESET;
            count_reg    <= wdt_pkg::RELOAD_RESET;
            running_reg  <= 1'b1;
            rst_req_reg  <= 1'b0;
            int_stat_reg <= '0;
            int_en_reg   <= '0;
            irq_reg      <= 1'b0;
        end else begin
            aw_held_reg  <= aw_held_next;
            aw_addr_reg  <= aw_addr_next;
            w_held_reg   <= w_held_next;
            w_data_reg   <= w_data_next;
            w_strb_reg   <= w_strb_next;
            awready_reg  <= awready_next;
            wready_reg   <= wready_next;
            bvalid_reg   <= bvalid_next;
            bresp_reg    <= bresp_next;
            arready_reg  <= arready_next;
            rvalid_reg   <= rvalid_next;
            rdata_reg    <= rdata_next;
            rresp_reg    <= rresp_next;
            ctrl_reg     <= ctrl_next;
            reload_reg   <= reload_next;
            window_reg   <= window_next;
            count_reg    <= count_next;
            running_reg  <= running_next;
            rst_req_reg  <= rst_req_next;
            int_stat_reg <= int_stat_next;
            int_en_reg   <= int_en_next;
            irq_reg      <= irq_next;
        end
    end

    assign awready       = awready_reg;
    assign wready        = wready_reg;
    assign bvalid        = bvalid_reg;
    assign bresp         = bresp_reg;
    assign arready       = arready_reg;
    assign rvalid        = rvalid_reg;
    assign rdata         = rdata_reg;
    assign rresp         = rresp_reg;
    assign reset_request = rst_req_reg;
    assign irq           = irq_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_starts_running: assert property ($rose(aresetn) |-> running_reg && count_reg == reload_reg)
        else $error("watchdog not running after reset");

    a_disable_stops: assert property (cmd.halt |=> !running_reg ##1 $stable(count_reg))
        else $error("watchdog kept counting after disable");

    a_overflow_request: assert property (overflow |=> reset_request && int_stat_reg.overflow
                                         && count_reg == $past(reload_reg))
        else $error("overflow gave no reset request");

    a_window_request: assert property (svc_req && running_reg && count_reg < window_reg
                                       |=> reset_request && int_stat_reg.window_violation
                                       && count_reg == $past(count_reg) + {15'h0, $past(tick)})
        else $error("service inside window was not refused");

    a_count_holds: assert property (!tick && !svc_req |=> $stable(count_reg))
        else $error("counter moved without a divided tick");

    a_service_reload: assert property (svc_req && !(running_reg && count_reg < window_reg)
                                       |=> count_reg == $past(reload_reg) && !reset_request)
        else $error("valid service did not reload");

    a_reset_defaults: assert property ($rose(aresetn) |-> reload_reg == wdt_pkg::RELOAD_RESET
                                       && ctrl_reg.clk_sel && !ctrl_reg.div_sel)
        else $error("reset defaults wrong");

    a_count_step: assert property (running_reg && tick && !svc_req && count_reg != wdt_pkg::COUNT_MAX
                                   |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("counter did not step by one");

endmodule // window_watchdog_timer

/* File: test/tb.sv */
// Self-checking bench for the window watchdog timer, driven over AXI4-Lite.
// Assumes the design package is compiled first and a single 20 MHz aclk domain.
`timescale 1ns/10ps
module tb;
    // --------------------------------------------------------------
    // Signals and instance
    // --------------------------------------------------------------
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid, reset_request, irq;
    logic        wakeup_clk = 1'b0;
    int          wu_div = 0, rr_count = 0, err_count = 0, cmp_count = 0, n, base;
    logic [1:0]  resp;
    logic [31:0] d;

    window_watchdog_timer i_window_watchdog_timer (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .wakeup_oscillator_clock(wakeup_clk), .reset_request(reset_request), .irq(irq));

    always #25 aclk = ~aclk;

    // Wake-up source at 500 kHz: 40 aclk cycles per period, synchronous to aclk
    always @(posedge aclk) begin
        if (wu_div == 19) begin
            wu_div <= 0;
            wakeup_clk <= ~wakeup_clk;
        end else begin
            wu_div <= wu_div + 1;
        end
    end

    // Reset request is a one-cycle pulse, so each high sample is one request
    always @(posedge aclk) begin
        if (reset_request === 1'b1) rr_count <= rr_count + 1;
    end

    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int k;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 200; k++) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (k == 200) begin
            err_count++;
            finish_test;
        end
    endtask

    task automatic rd(input logic [7:0] a);
        int k;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 200; k++) begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (k == 200) begin
            err_count++;
            finish_test;
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
        rd(a);
        chk(d, exp, msg);
    endtask

    // Bounded wait for the next reset request; n returns the cycles waited
    task automatic wait_rr;
        base = rr_count;
        for (n = 0; n < 3000 && rr_count == base; n++) @(posedge aclk);
        if (n == 3000) begin
            err_count++;
            finish_test;
        end
    endtask

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        #(4_000_000);
        err_count++;
        finish_test;
    end

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(wdt_pkg::OFF_STATE, 32'h0001ff03, "running from reload after reset");
        // 0.13 s at 500 kHz divided by 256 gives 253 ticks before the wrap
        rd_chk(wdt_pkg::OFF_RELOAD, 32'(65536 - 130000 * 500 / 1000 / 256), "reload default");
        rd_chk(wdt_pkg::OFF_CONTROL, 32'h00000001, "wake-up clock, divide 256");
        rd_chk(wdt_pkg::OFF_WINDOW, 32'h00000000, "window default");
        rd_chk(8'h20, 32'h00000000, "unmapped read data");
        chk({30'h0, resp}, {30'h0, wdt_pkg::RESP_SLVERR}, "unmapped read resp");
        wr(8'h24, 32'h1);
        chk({30'h0, resp}, {30'h0, wdt_pkg::RESP_SLVERR}, "unmapped write resp");
        // Service reloads the counter
        wr(wdt_pkg::OFF_CONTROL, 32'h0);
        wr(wdt_pkg::OFF_RELOAD, 32'h1234);
        wr(wdt_pkg::OFF_COMMAND, 32'h1);
        rd_chk(wdt_pkg::OFF_STATE, 32'h00011234, "count after service");
        // Service inside the window: request, no reload
        wr(wdt_pkg::OFF_WINDOW, 32'h2000);
        wr(wdt_pkg::OFF_RELOAD, 32'h1000);
        wr(wdt_pkg::OFF_INT_ENABLE, 32'h3);
        base = rr_count;
        wr(wdt_pkg::OFF_COMMAND, 32'h1);
        repeat (3) @(posedge aclk);
        chk(32'(rr_count - base), 32'h1, "window violation request");
        rd_chk(wdt_pkg::OFF_STATE, 32'h00011234, "no reload on violation");
        rd_chk(wdt_pkg::OFF_INT_STATUS, 32'h2, "violation status");
        chk({31'h0, irq}, 32'h1, "irq on violation");
        wr(wdt_pkg::OFF_INT_CLEAR, 32'h3);
        rd_chk(wdt_pkg::OFF_INT_STATUS, 32'h0, "status cleared");
        chk({31'h0, irq}, 32'h0, "irq cleared");
        // Overflow: two ticks of 256 system clocks from 0xfffe
        wr(wdt_pkg::OFF_WINDOW, 32'h0);
        wr(wdt_pkg::OFF_RELOAD, 32'hfffe);
        wr(wdt_pkg::OFF_COMMAND, 32'h1);
        wait_rr;
        chk(32'(n >= 505 && n <= 520), 32'h1, "overflow after two ticks");
        rd_chk(wdt_pkg::OFF_INT_STATUS, 32'h1, "overflow status");
        chk({31'h0, irq}, 32'h1, "irq on overflow");
        rd_chk(wdt_pkg::OFF_STATE, 32'h0001fffe, "restart from reload");
        // Disabled counter holds and never overflows
        wr(wdt_pkg::OFF_COMMAND, 32'h2);
        base = rr_count;
        repeat (1200) @(posedge aclk);
        chk(32'(rr_count - base), 32'h0, "no request while stopped");
        rd_chk(wdt_pkg::OFF_STATE, 32'h0000fffe, "stopped count");
        wr(wdt_pkg::OFF_COMMAND, 32'h4);
        rd_chk(wdt_pkg::OFF_STATE, 32'h0001fffe, "running again");
        // Divider and source selection, one tick from reload zero
        wr(wdt_pkg::OFF_INT_CLEAR, 32'h3);
        wr(wdt_pkg::OFF_RELOAD, 32'h0);
        wr(wdt_pkg::OFF_CONTROL, 32'h2);
        wr(wdt_pkg::OFF_COMMAND, 32'h1);
        repeat (16000) @(posedge aclk);
        rd_chk(wdt_pkg::OFF_STATE, 32'h00010000, "no tick before 16384");
        repeat (500) @(posedge aclk);
        rd_chk(wdt_pkg::OFF_STATE, 32'h00010001, "tick after 16384");
        wr(wdt_pkg::OFF_CONTROL, 32'h0);
        wr(wdt_pkg::OFF_COMMAND, 32'h1);
        repeat (240) @(posedge aclk);
        rd_chk(wdt_pkg::OFF_STATE, 32'h00010000, "no tick before 256");
        repeat (30) @(posedge aclk);
        rd_chk(wdt_pkg::OFF_STATE, 32'h00010001, "tick after 256");
        wr(wdt_pkg::OFF_CONTROL, 32'h1);
        wr(wdt_pkg::OFF_COMMAND, 32'h1);
        repeat (300) @(posedge aclk);
        rd_chk(wdt_pkg::OFF_STATE, 32'h00010000, "wake-up source ignores aclk");
        repeat (10400) @(posedge aclk);
        rd_chk(wdt_pkg::OFF_STATE, 32'h00010001, "tick after 256 wake-up edges");
        finish_test;
    end
endmodule // tb
